// file: acc_pkg.sv
package acc_pkg;
  // register byte offsets
  localparam logic [2:0] ACC_OFS_CTL0 = 3'h0;
  localparam logic [2:0] ACC_OFS_CTL1 = 3'h1;
  localparam logic [2:0] ACC_OFS_RES_LO = 3'h2;
  localparam logic [2:0] ACC_OFS_RES_HI = 3'h3;
  localparam logic [2:0] ACC_OFS_IRQ = 3'h4;
  // conv_control_0 fields
  localparam int ACC_C0_START = 7;
  localparam int ACC_C0_BUSY = 6;
  localparam int ACC_C0_PD = 5;
  localparam int ACC_C0_ALIGN = 4;
  localparam int ACC_C0_CH_LSB = 0;
  // conv_control_1 fields
  localparam int ACC_C1_CH4 = 7;
  localparam int ACC_C1_BG = 6;
  localparam int ACC_C1_REF = 4;
  localparam int ACC_C1_DIV_LSB = 0;
  // irq register fields
  localparam int ACC_IR_REQ = 0;
  localparam int ACC_IR_EN = 1;
  localparam int ACC_IR_GLB = 2;
  // reset values
  localparam logic ACC_RST_PD = 1'b1;
  localparam logic ACC_RST_BUSY = 1'b1;
  localparam logic [2:0] ACC_RST_DIV = 3'h0;
  // conversion timing in converter clock periods
  localparam logic [3:0] ACC_SAMPLE_PER = 4'h4;
  localparam logic [3:0] ACC_LAST_PER = 4'hf;
  localparam int ACC_RES_W = 12;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_ARMED = 2'b01,
    ACC_CONV = 2'b10
  } acc_state_e;
endpackage

// file: acc_clk_div.sv
module acc_clk_div
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic restart,
  input wire logic [2:0] div_sel,
  output logic tick
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;

  // code 111 is undefined; it is run as the slowest ratio
  function automatic logic [5:0] div_limit(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel == 3'h7) ? 3'h6 : sel;
    return 6'((7'h01 << s) - 7'h01);
  endfunction

  assign tick = clk_en && !restart && (cnt_r >= div_limit(div_sel));

  always_comb begin
    cnt_nxt = cnt_r;
    if (restart || tick) begin
      cnt_nxt = 6'h00;
    end else begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= 6'h00;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// file: acc_conv_ctrl.sv
// Overview of operation
// - converter powered only while power-down is zero; software waits first.
// - reference-select bit picks supply rail or external reference pin.
// - reference-select high hands the shared pin to its reference function.
// - interrupt reaches processor only with global and converter enables set.
// - busy flag falling marks completion; both result bytes then valid.
// - conversion runs in hardware without stalling the processor.
// - each conversion lasts exactly sixteen divided converter clock periods.
// - result is 12-bit unsigned, one step equals reference over 4096.
// - codes step half LSB early; last transition 1.5 LSB below reference.
// - start rising resets converter, sets busy; conversion begins on falling.
// - at completion busy clears and interrupt request flag sets.
// - divider codes 0..6 give system clock over 1..64; code 7 undefined.
// - format 0 left-aligns result, format 1 right-aligns it.
//
// Chosen here: the plain strobed port and the address map.
module acc_conv_ctrl
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic comp_in,
  output logic [ACC_RES_W-1:0] dac_code,
  output logic sample_hold,
  output logic analog_power_en,
  output logic ref_source_select,
  output logic vref_pin_func_en,
  output logic [4:0] input_channel_select,
  output logic bandgap_enable,
  output logic conv_irq
);
  acc_state_e state_r, state_nxt;
  logic start_r, start_nxt;
  logic busy_r, busy_nxt;
  logic pd_r, pd_nxt;
  logic align_r, align_nxt;
  logic [4:0] ch_r, ch_nxt;
  logic bg_r, bg_nxt;
  logic ref_r, ref_nxt;
  logic [2:0] div_r, div_nxt;
  logic req_r, req_nxt;
  logic ien_r, ien_nxt;
  logic gie_r, gie_nxt;
  logic [3:0] per_r, per_nxt;
  logic [ACC_RES_W-1:0] sar_r, sar_nxt;
  logic [ACC_RES_W-1:0] res_r, res_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic wr_c0, wr_c1, wr_irq;
  logic start_rise, start_fall, tick, done;
  logic [3:0] bit_idx;

  assign wr_c0 = reg_wr && (reg_addr == ACC_OFS_CTL0);
  assign wr_c1 = reg_wr && (reg_addr == ACC_OFS_CTL1);
  assign wr_irq = reg_wr && (reg_addr == ACC_OFS_IRQ);
  assign start_rise = wr_c0 && reg_wdata[ACC_C0_START] && !start_r;
  assign start_fall = wr_c0 && !reg_wdata[ACC_C0_START] && start_r;
  assign bit_idx = 4'(ACC_LAST_PER - per_r);
  assign done = (state_r == ACC_CONV) && tick && (per_r == ACC_LAST_PER);

  acc_clk_div u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .restart(state_r != ACC_CONV),
    .div_sel(div_r),
    .tick(tick)
  );

  function automatic logic [15:0] acc_format(
    input logic [ACC_RES_W-1:0] r, input logic right);
    return right ? {4'h0, r} : {r, 4'h0};
  endfunction

  // control and status registers
  always_comb begin
    start_nxt = start_r;
    pd_nxt = pd_r;
    align_nxt = align_r;
    ch_nxt = ch_r;
    bg_nxt = bg_r;
    ref_nxt = ref_r;
    div_nxt = div_r;
    ien_nxt = ien_r;
    gie_nxt = gie_r;
    req_nxt = req_r;
    if (wr_c0) begin
      start_nxt = reg_wdata[ACC_C0_START];
      pd_nxt = reg_wdata[ACC_C0_PD];
      align_nxt = reg_wdata[ACC_C0_ALIGN];
      ch_nxt[3:0] = reg_wdata[ACC_C0_CH_LSB +: 4];
    end
    if (wr_c1) begin
      ch_nxt[4] = reg_wdata[ACC_C1_CH4];
      bg_nxt = reg_wdata[ACC_C1_BG];
      ref_nxt = reg_wdata[ACC_C1_REF];
      div_nxt = reg_wdata[ACC_C1_DIV_LSB +: 3];
    end
    if (wr_irq) begin
      req_nxt = reg_wdata[ACC_IR_REQ];
      ien_nxt = reg_wdata[ACC_IR_EN];
      gie_nxt = reg_wdata[ACC_IR_GLB];
    end
    // a completion in the same cycle as a software clear is kept
    if (done) begin
      req_nxt = 1'b1;
    end
  end

  // conversion sequencer
  always_comb begin
    state_nxt = state_r;
    busy_nxt = busy_r;
    per_nxt = per_r;
    sar_nxt = sar_r;
    res_nxt = res_r;
    if (start_rise) begin
      state_nxt = ACC_ARMED;
      busy_nxt = 1'b1;
      per_nxt = 4'h0;
      sar_nxt = '0;
    end else begin
      case (state_r)
        ACC_IDLE: begin
          state_nxt = ACC_IDLE;
        end
        ACC_ARMED: begin
          // a conversion only begins on a powered converter
          if (start_fall && !pd_nxt) begin
            state_nxt = ACC_CONV;
          end else if (start_fall) begin
            state_nxt = ACC_IDLE;
          end
        end
        ACC_CONV: begin
          // powering down mid-conversion abandons it, busy stays high
          if (pd_r) begin
            state_nxt = ACC_IDLE;
          end else if (tick) begin
            per_nxt = per_r + 4'h1;
            if (per_r == ACC_SAMPLE_PER - 4'h1) begin
              sar_nxt[ACC_RES_W-1] = 1'b1;
            end else if (per_r >= ACC_SAMPLE_PER) begin
              if (!comp_in) begin
                sar_nxt[bit_idx] = 1'b0;
              end
              if (bit_idx != 4'h0) begin
                sar_nxt[bit_idx - 4'h1] = 1'b1;
              end
            end
            if (done) begin
              state_nxt = ACC_IDLE;
              busy_nxt = 1'b0;
              // both bytes come from one register
              res_nxt = sar_nxt;
            end
          end
        end
        default: begin
          state_nxt = ACC_IDLE;
        end
      endcase
    end
  end

  // read port: data stand in the cycle after the strobe
  always_comb begin
    logic [15:0] fmt;
    fmt = acc_format(res_r, align_r);
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ACC_OFS_CTL0: rdata_nxt = {start_r, busy_r, pd_r, align_r, ch_r[3:0]};
        ACC_OFS_CTL1: rdata_nxt = {ch_r[4], bg_r, 1'b0, ref_r, 1'b0, div_r};
        ACC_OFS_RES_LO: rdata_nxt = fmt[7:0];
        ACC_OFS_RES_HI: rdata_nxt = fmt[15:8];
        ACC_OFS_IRQ: rdata_nxt = {5'h00, gie_r, ien_r, req_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= ACC_IDLE;
      start_r <= 1'b0;
      busy_r <= ACC_RST_BUSY;
      pd_r <= ACC_RST_PD;
      align_r <= 1'b0;
      ch_r <= 5'h00;
      bg_r <= 1'b0;
      ref_r <= 1'b0;
      div_r <= ACC_RST_DIV;
      req_r <= 1'b0;
      ien_r <= 1'b0;
      gie_r <= 1'b0;
      per_r <= 4'h0;
      sar_r <= '0;
      res_r <= '0;
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      state_r <= state_nxt;
      start_r <= start_nxt;
      busy_r <= busy_nxt;
      pd_r <= pd_nxt;
      align_r <= align_nxt;
      ch_r <= ch_nxt;
      bg_r <= bg_nxt;
      ref_r <= ref_nxt;
      div_r <= div_nxt;
      req_r <= req_nxt;
      ien_r <= ien_nxt;
      gie_r <= gie_nxt;
      per_r <= per_nxt;
      sar_r <= sar_nxt;
      res_r <= res_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  // trial code; the half-LSB early step is the DAC's offset
  assign dac_code = sar_r;
  assign sample_hold = (state_r == ACC_CONV) && (per_r < ACC_SAMPLE_PER);
  assign analog_power_en = !pd_r;
  assign ref_source_select = ref_r;
  assign vref_pin_func_en = ref_r;
  assign input_channel_select = ch_r;
  assign bandgap_enable = bg_r;
  assign conv_irq = req_r && ien_r && gie_r;
endmodule

// file: acc_conv_ctrl_checker.sv
module acc_chk
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_hold,
  input wire logic analog_power_en,
  input wire logic ref_source_select,
  input wire logic vref_pin_func_en,
  input wire logic [4:0] input_channel_select,
  input wire logic bandgap_enable,
  input wire logic conv_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic w0 = reg_wr & clk_en & (reg_addr == ACC_OFS_CTL0);
  wire logic w1 = reg_wr & clk_en & (reg_addr == ACC_OFS_CTL1);
  wire logic rv = reg_rd & clk_en;
  AST_PIN: assert property (
    w1 |=> vref_pin_func_en == $past(reg_wdata[ACC_C1_REF]))
    else $error("ref pin function not taken from write");
  AST_REF: assert property (
    w1 |=> ref_source_select == $past(reg_wdata[ACC_C1_REF]))
    else $error("ref select not taken from write");
  AST_PWR: assert property (
    w0 |=> analog_power_en == !$past(reg_wdata[ACC_C0_PD]))
    else $error("power enable not inverse of power down bit");
  AST_CH: assert property (
    w0 |=> input_channel_select[3:0] ==
      $past(reg_wdata[ACC_C0_CH_LSB +: 4]))
    else $error("low channel bits not taken");
  AST_CH4: assert property (
    w1 |=> {input_channel_select[4], bandgap_enable} ==
      $past({reg_wdata[ACC_C1_CH4], reg_wdata[ACC_C1_BG]}))
    else $error("top channel bit or bandgap not taken");
  // the line is compared as it stood when the read was taken
  AST_IRQ: assert property (
    rv && reg_addr == ACC_OFS_IRQ |=> $past(conv_irq) ==
      (reg_rdata[ACC_IR_REQ] & reg_rdata[ACC_IR_EN] & reg_rdata[ACC_IR_GLB]))
    else $error("irq line disagrees with enables and request");
  AST_SH: assert property ($rose(sample_hold) |-> sample_hold [*4])
    else $error("sample phase shorter than four periods");
  AST_ARM: assert property (
    w0 && reg_wdata[ACC_C0_START] |=> !sample_hold)
    else $error("start rise did not reset converter");
  AST_BUSY: assert property (
    rv && reg_addr == ACC_OFS_CTL0 && sample_hold |=>
      reg_rdata[ACC_C0_BUSY])
    else $error("busy low while sampling");
  AST_FRZ: assert property (
    !clk_en && rst_n |=> $stable({analog_power_en, ref_source_select,
      sample_hold, input_channel_select, bandgap_enable, conv_irq,
      reg_rdata}))
    else $error("outputs moved while clock enable low");
endmodule
bind acc_conv_ctrl acc_chk u_chk (.core_clk, .rst_n, .clk_en, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_hold, .analog_power_en,
  .ref_source_select, .vref_pin_func_en, .input_channel_select,
  .bandgap_enable, .conv_irq);

// file: tb.sv
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, rd_v, reg_rdata;
  logic [11:0] vin = 12'h000, v, dac_code;
  logic sample_hold, analog_power_en, ref_source_select, vref_pin_func_en;
  logic bandgap_enable, conv_irq;
  logic [4:0] input_channel_select;
  int n_fail = 0, n_tests = 0, cyc = 0, n;
  // ideal comparator; must be combinational so the decision meets its period
  wire logic comp_in = (vin >= dac_code);
  acc_conv_ctrl uut (.core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .comp_in, .dac_code, .sample_hold,
    .analog_power_en, .ref_source_select, .vref_pin_func_en,
    .input_channel_select, .bandgap_enable, .conv_irq);
  initial forever #4 core_clk = ~core_clk;
  task results();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 9000) begin
      n_fail++;
      results();
    end
  end
  // one idle edge after each strobe keeps a signal to one assignment a step
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(ACC_OFS_CTL0, rd_v);
    `CHK("ctl0", 8'h60, rd_v)
    rd(ACC_OFS_CTL1, rd_v);
    `CHK("ctl1", 8'h00, rd_v)
    rd(3'h5, rd_v);
    `CHK("unmapped", 8'h00, rd_v)
    `CHK("power", 1'b0, analog_power_en)
    // a write while the clock enable is low must leave every register alone
    clk_en <= 1'b0;
    wr(ACC_OFS_CTL1, 8'h17);
    clk_en <= 1'b1;
    rd(ACC_OFS_CTL1, rd_v);
    `CHK("frozen", 8'h00, rd_v)
    $display("test reset done");
    for (int d = 0; d < 8; d++) begin
      v = d == 0 ? 12'h000 : d == 7 ? 12'hfff : 12'(12'h2c9 * d);
      vin = v;
      n = 16 << (d == 7 ? 6 : d);
      wr(ACC_OFS_IRQ, d == 7 ? 8'h02 : 8'h06);
      wr(ACC_OFS_CTL1, {d[0], d[1], 1'b0, d[0], 1'b0, d[2:0]});
      // channel pins are taken as already shared out as analog inputs
      wr(ACC_OFS_CTL0, {3'b100, d[0], d[3:0]});
      `CHK("chan", {d[0], d[3:0]}, input_channel_select)
      `CHK("refpin", d[0], vref_pin_func_en)
      `CHK("refsel", d[0], ref_source_select)
      `CHK("bandgap", d[1], bandgap_enable)
      `CHK("power on", 1'b1, analog_power_en)
      wr(ACC_OFS_CTL0, {3'b000, d[0], d[3:0]});
      repeat (n - 2) @(posedge core_clk);
      #1 `CHK("irq early", 1'b0, conv_irq)
      @(posedge core_clk);
      #1 `CHK("irq done", d != 7, conv_irq)
      rd(ACC_OFS_CTL0, rd_v);
      `CHK("busy", 1'b0, rd_v[ACC_C0_BUSY])
      rd(ACC_OFS_RES_HI, rd_v);
      `CHK("res hi", d[0] ? {4'h0, v[11:8]} : v[11:4], rd_v)
      rd(ACC_OFS_RES_LO, rd_v);
      `CHK("res lo", d[0] ? v[7:0] : {v[3:0], 4'h0}, rd_v)
      rd(ACC_OFS_IRQ, rd_v);
      `CHK("irq reg", d == 7 ? 8'h03 : 8'h07, rd_v)
      wr(ACC_OFS_IRQ, 8'h06);
      `CHK("irq clr", 1'b0, conv_irq)
      $display("test divider %0d done", d);
    end
    vin = 12'h0f0;
    wr(ACC_OFS_CTL0, 8'h90);
    wr(ACC_OFS_CTL0, 8'h10);
    repeat (40) @(posedge core_clk);
    rd(ACC_OFS_CTL0, rd_v);
    `CHK("busy mid", 1'b1, rd_v[ACC_C0_BUSY])
    `CHK("sampling", 1'b1, sample_hold)
    `CHK("trial", 12'h000, dac_code)
    wr(ACC_OFS_CTL0, 8'hb0);
    wr(ACC_OFS_CTL0, 8'h30);
    repeat (1100) @(posedge core_clk);
    rd(ACC_OFS_CTL0, rd_v);
    `CHK("aborted", 8'h70, rd_v)
    `CHK("power off", 1'b0, analog_power_en)
    rd(ACC_OFS_RES_HI, rd_v);
    `CHK("kept hi", 8'h0f, rd_v)
    rd(ACC_OFS_RES_LO, rd_v);
    `CHK("kept lo", 8'hff, rd_v)
    $display("test abort done");
    results();
  end
endmodule
